// ===== ffp_flash_seq.sv
// APB-controlled flash unlock, page erase and page write sequencer
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module ffp_flash_seq #(
   parameter int unsigned PROG_CYCLES   = ffp_pkg::PROG_CYC,
   parameter int unsigned UNLOCK_CYCLES = ffp_pkg::UNLOCK_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             cpu_stall,
   output logic             flash_erase,
   output logic             flash_write,
   output logic      [6:0]  flash_page,
   input  wire logic [4:0]  flash_buf_idx,
   output logic      [15:0] flash_buf_data
);
   import ffp_pkg::*;

   // ==========================================================
   // State
   ffp_state_t  state_q;
   logic        granted_q;
   logic [2:0]  opsel_q;
   logic [11:0] addr_q;
   logic [7:0]  wlo_q;
   logic [7:0]  whi_q;
   logic [47:0] key_q;
   logic        unlock_done;
   logic        prog_done;
   logic        wr_en;
   logic [7:0]  wdat;
   logic        ctrl_wr;
   logic        start_unlock;
   logic        start_prog;
   logic        revoke;
   logic        hw_grant;
   logic [2:0]  new_op;

   ffp_wbuf_if #(.AW(WIDX_BITS), .DW(WORD_BITS)) wb ();

   // ==========================================================
   // Bus decode
   function automatic logic mapped(input logic [11:0] a);
      mapped = (a[1:0] == 2'b00) && (a <= KEY_LAST);
   endfunction : mapped

   function automatic logic [2:0] key_index(input logic [11:0] a);
      logic [11:0] off;
      off = a - KEY_OFS;
      key_index = off[4:2];
   endfunction : key_index

   assign wr_en   = psel && penable && pready && pwrite;
   assign wdat    = pwdata[7:0];
   assign ctrl_wr = wr_en && (paddr == CTRL_OFS);
   assign new_op  = wdat[OPSEL_LSB +: 3];

   // Trigger only counts when the same write selects unlock mode
   assign start_unlock = ctrl_wr && wdat[TRIG_BIT]
                         && (new_op == OP_UNLOCK)
                         && (state_q == ST_IDLE);

   // Go without permission or with a reserved code never starts
   assign start_prog = ctrl_wr && wdat[GO_BIT] && granted_q
                       && wdat[GRANT_BIT]
                       && ((new_op == OP_WRITE)
                           || (new_op == OP_ERASE))
                       && (state_q == ST_IDLE)
                       && !wb.wipe_busy;

   assign revoke   = ctrl_wr && !wdat[GRANT_BIT];
   assign hw_grant = unlock_done
                     && (key_q == KEY_PATTERN);

   // ==========================================================
   // APB slave: zero wait states, read data captured in setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pready  <= 1'b1;
         pslverr <= !mapped(paddr);
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= 32'h0000_0000;
         if (paddr == CTRL_OFS) begin
            prdata[GRANT_BIT]         <= granted_q;
            prdata[OPSEL_LSB +: 3]    <= opsel_q;
            prdata[TRIG_BIT]          <= (state_q == ST_UNLOCK);
            prdata[GO_BIT]            <= (state_q == ST_PROG);
         end else if (paddr == WIPE_OFS) begin
            prdata[WIPE_BIT] <= wb.wipe_busy;
         end else if (paddr == ADDRL_OFS) begin
            prdata[7:0] <= addr_q[7:0];
         end else if (paddr == ADDRH_OFS) begin
            prdata[3:0] <= addr_q[11:8];
         end else if (paddr == WLO_OFS) begin
            prdata[7:0] <= wlo_q;
         end else if (paddr == WHI_OFS) begin
            prdata[7:0] <= whi_q;
         end else if (mapped(paddr)) begin
            prdata[7:0] <= key_q[key_index(paddr)*8 +: 8];
         end
      end
   end

   // ==========================================================
   // Mode select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opsel_q <= REG_RST[2:0];
      end else if (ctrl_wr && (state_q == ST_IDLE)) begin
         opsel_q <= new_op;
      end
   end

   // ==========================================================
   // Granted flag: hardware set wins over a same-cycle clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         granted_q <= 1'b0;
      end else if (hw_grant) begin
         granted_q <= 1'b1;
      end else if (revoke) begin
         granted_q <= 1'b0;
      end else if (unlock_done) begin
         granted_q <= granted_q;
      end
      // A written one at the flag bit is simply dropped
   end

   // ==========================================================
   // Sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (start_unlock) begin
                  state_q <= ST_UNLOCK;
               end else if (start_prog) begin
                  state_q <= ST_PROG;
               end
            end
            ST_UNLOCK: begin
               if (unlock_done) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_PROG: begin
               if (prog_done || revoke) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   ffp_timer #(.CYCLES(UNLOCK_CYCLES)) u_unlock_tmr (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (start_unlock),
      .abort   (1'b0),
      .done    (unlock_done)
   );

   ffp_timer #(.CYCLES(PROG_CYCLES)) u_prog_tmr (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (start_prog),
      .abort   (revoke),
      .done    (prog_done)
   );

   // ==========================================================
   // Key registers, cleared after each check so keys never replay
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_q <= {KEY_BYTES{REG_RST}};
      end else if (unlock_done) begin
         key_q <= {KEY_BYTES{REG_RST}};
      end else if (wr_en && mapped(paddr) && (paddr >= KEY_OFS)) begin
         key_q[key_index(paddr)*8 +: 8] <= wdat;
      end
   end

   // ==========================================================
   // Data byte registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wlo_q <= REG_RST;
         whi_q <= REG_RST;
      end else if (wr_en && (paddr == WLO_OFS)) begin
         wlo_q <= wdat;
      end else if (wr_en && (paddr == WHI_OFS)) begin
         whi_q <= wdat;
      end
   end

   // ==========================================================
   // Address pair with word auto-increment inside the page
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_q <= ADDR_RST;
      end else if (wr_en && (paddr == ADDRL_OFS)) begin
         addr_q[7:0] <= wdat;
      end else if (wr_en && (paddr == ADDRH_OFS)) begin
         addr_q[11:8] <= wdat[3:0];
      end else if (wb.load && (addr_q[4:0] != 5'h1F)) begin
         addr_q[4:0] <= addr_q[4:0] + 5'h01;
      end
      // Last word of the page holds its place
   end

   // High byte write commits the whole word to the buffer
   assign wb.load      = wr_en && (paddr == WHI_OFS)
                         && !wb.wipe_busy;
   assign wb.load_idx  = addr_q[4:0];
   assign wb.load_data = {wdat, wlo_q};
   assign wb.wipe_start = wr_en && (paddr == WIPE_OFS)
                          && wdat[WIPE_BIT]
                          && (state_q != ST_PROG);
   assign wb.rd_idx    = flash_buf_idx;

   ffp_wbuf #(.WORDS(PAGE_WORDS)) u_wbuf (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (wb)
   );

   assign flash_buf_data = wb.rd_data;

   // ==========================================================
   // Flash array strobes and CPU stall
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_erase <= 1'b0;
         flash_write <= 1'b0;
         flash_page  <= 7'h00;
         cpu_stall   <= 1'b0;
      end else if (start_prog) begin
         flash_erase <= (new_op == OP_ERASE);
         flash_write <= (new_op == OP_WRITE);
         flash_page  <= addr_q[11:5];
         cpu_stall   <= 1'b1;
      end else if (prog_done || revoke) begin
         flash_erase <= 1'b0;
         flash_write <= 1'b0;
         cpu_stall   <= 1'b0;
      end
   end
endmodule : ffp_flash_seq

// ===== ffp_pkg.sv
// Constants and types for the flash erase/write unlock sequencer
package ffp_pkg;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [11:0] CTRL_OFS  = 12'h000;
   localparam logic [11:0] WIPE_OFS  = 12'h004;
   localparam logic [11:0] ADDRL_OFS = 12'h008;
   localparam logic [11:0] ADDRH_OFS = 12'h00C;
   localparam logic [11:0] WLO_OFS   = 12'h010;
   localparam logic [11:0] WHI_OFS   = 12'h014;
   localparam logic [11:0] KEY_OFS   = 12'h018;
   localparam logic [11:0] KEY_LAST  = 12'h02C;
   // ==========================================================
   // Field positions
   localparam int GRANT_BIT = 7;
   localparam int OPSEL_LSB = 4;
   localparam int TRIG_BIT  = 3;
   localparam int GO_BIT    = 2;
   localparam int WIPE_BIT  = 0;
   // ==========================================================
   // Reset values and codes
   localparam logic [7:0]  REG_RST  = 8'h00;
   localparam logic [11:0] ADDR_RST = 12'h000;
   localparam logic [15:0] WBUF_CLR = 16'h0000;
   localparam logic [2:0]  OP_WRITE  = 3'h0;
   localparam logic [2:0]  OP_ERASE  = 3'h1;
   localparam logic [2:0]  OP_UNLOCK = 3'h6;
   // Byte order: low first..third, then high first..third
   localparam logic [47:0] KEY_PATTERN = 48'h40_09_04_C3_0D_00;
   localparam int KEY_BYTES  = 6;
   localparam int PAGE_WORDS = 32;
   localparam int WORD_BITS  = 16;
   localparam int WIDX_BITS  = 5;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int PROG_TIME_NS  = 2200000;
   localparam int PROG_CYC      = PROG_TIME_NS / CLK_PERIOD_NS;
   localparam int UNLOCK_CYC    = 1024;
   // ==========================================================
   // Sequencer states, Gray along idle-unlock and idle-prog
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_UNLOCK = 2'b01,
      ST_PROG   = 2'b10
   } ffp_state_t;
endpackage : ffp_pkg

// ===== ffp_wbuf_if.sv
// Connection between sequencer and its page write buffer
`timescale 1ns/100ps
interface ffp_wbuf_if #(
   parameter int AW = 5,
   parameter int DW = 16
);
   logic          load;
   logic [AW-1:0] load_idx;
   logic [DW-1:0] load_data;
   logic          wipe_start;
   logic          wipe_busy;
   logic [AW-1:0] rd_idx;
   logic [DW-1:0] rd_data;
   modport ctrl  (output load, load_idx, load_data, wipe_start,
                  rd_idx, input wipe_busy, rd_data);
   modport store (input load, load_idx, load_data, wipe_start,
                  rd_idx, output wipe_busy, rd_data);
endinterface : ffp_wbuf_if

// ===== ffp_timer.sv
// Down counter that reports a one-cycle pulse on expiry
`timescale 1ns/100ps
module ffp_timer #(
   parameter int unsigned CYCLES = 16
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic start,
   input  wire logic abort,
   output logic      done
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] cnt_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (abort) begin
            cnt_q <= '0;
         end else if (start) begin
            cnt_q <= W'(CYCLES);
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
            done  <= (cnt_q == W'(1));
         end
      end
   end
endmodule : ffp_timer

// ===== ffp_wbuf.sv
// Page write buffer with word load and self-timed wipe
`timescale 1ns/100ps
module ffp_wbuf #(
   parameter int WORDS = ffp_pkg::PAGE_WORDS
) (
   input  wire logic pclk,
   input  wire logic presetn,
   ffp_wbuf_if.store bus
);
   import ffp_pkg::*;
   localparam int AW = $clog2(WORDS);
   logic [WORD_BITS-1:0] mem_q [WORDS];
   logic [AW-1:0]        wipe_idx_q;

   // ==========================================================
   // Storage; a wipe takes one cycle per word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < WORDS; i++) begin
            mem_q[i] <= WBUF_CLR;
         end
      end else if (bus.wipe_busy) begin
         mem_q[wipe_idx_q] <= WBUF_CLR;
      end else if (bus.load) begin
         mem_q[bus.load_idx] <= bus.load_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus.wipe_busy <= 1'b0;
         wipe_idx_q    <= '0;
      end else if (bus.wipe_busy) begin
         wipe_idx_q <= wipe_idx_q + AW'(1);
         if (wipe_idx_q == AW'(WORDS - 1)) begin
            bus.wipe_busy <= 1'b0;
         end
      end else if (bus.wipe_start) begin
         bus.wipe_busy <= 1'b1;
         wipe_idx_q    <= '0;
      end
   end

   // Registered read port toward the flash array
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus.rd_data <= WBUF_CLR;
      end else begin
         bus.rd_data <= mem_q[bus.rd_idx];
      end
   end
endmodule : ffp_wbuf

// ===== ffp_flash_seq_assertions.sv
// Port checker for the flash unlock, erase and write sequencer
`timescale 1ns/100ps
module ffp_flash_seq_chk #(
   parameter int unsigned PROG_CYCLES = 20
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        cpu_stall,
   input wire logic        flash_erase,
   input wire logic        flash_write,
   input wire logic [6:0]  flash_page,
   input wire logic [4:0]  flash_buf_idx,
   input wire logic [15:0] flash_buf_data
);
   import ffp_pkg::*;
   // ==========================================================
   // Helper state
   logic        acc, ctrl_wr, go_wr, bad_addr, rev_q;
   logic [2:0]  op_wr;
   logic [31:0] busy_q;
   logic [6:0]  page_q;
   assign acc      = psel && penable && pready;
   assign ctrl_wr  = acc && pwrite && paddr == CTRL_OFS;
   assign go_wr    = ctrl_wr && pwdata[GO_BIT];
   assign op_wr    = pwdata[OPSEL_LSB +: 3];
   assign bad_addr = paddr[1:0] != 2'b00 || paddr > KEY_LAST;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) busy_q <= '0;
      else busy_q <= cpu_stall ? busy_q + 32'h1 : '0;
   end
   // An abort makes a short busy span legal, so remember it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rev_q <= 1'b0;
      else if (ctrl_wr && !pwdata[GRANT_BIT] && cpu_stall) rev_q <= 1'b1;
      else if (!cpu_stall) rev_q <= 1'b0;
   end
   // Loads only touch address bits 4..0, so the page stays put
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) page_q <= '0;
      else if (acc && pwrite && paddr == ADDRL_OFS) page_q[2:0] <= pwdata[7:5];
      else if (acc && pwrite && paddr == ADDRH_OFS) page_q[6:3] <= pwdata[3:0];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s; psel && !penable; endsequence
   sequence abort_s; ctrl_wr && !pwdata[GRANT_BIT] && cpu_stall; endsequence
   // ==========================================================
   // Properties
   chk_ready_setup:
      assert property (setup_s |=> pready) else $error("no pready");
   chk_err_addr:
      assert property (acc && bad_addr |-> pslverr) else $error("no pslverr");
   chk_stall_cover:
      assert property (flash_erase || flash_write |-> cpu_stall)
      else $error("operation without stall");
   chk_op_exclusive:
      assert property (!(flash_erase && flash_write)) else $error("both ops");
   chk_busy_span:
      assert property ($fell(cpu_stall) && !rev_q |->
         busy_q >= PROG_CYCLES && busy_q <= PROG_CYCLES + 2)
      else $error("busy span wrong");
   chk_revoke_stop:
      assert property (abort_s |=> !cpu_stall) else $error("abort ignored");
   chk_go_cause:
      assert property ($rose(cpu_stall) |-> $past(go_wr))
      else $error("stall without go");
   chk_erase_code:
      assert property ($rose(flash_erase) |-> $past(op_wr) == OP_ERASE)
      else $error("erase with wrong code");
   chk_write_code:
      assert property ($rose(flash_write) |-> $past(op_wr) == OP_WRITE)
      else $error("write with wrong code");
   chk_page_latch:
      assert property ($rose(cpu_stall) |-> flash_page == page_q)
      else $error("page mismatch");
endmodule : ffp_flash_seq_chk

bind ffp_flash_seq ffp_flash_seq_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .cpu_stall(cpu_stall),
   .flash_erase(flash_erase), .flash_write(flash_write),
   .flash_page(flash_page), .flash_buf_idx(flash_buf_idx),
   .flash_buf_data(flash_buf_data)
);

// ===== ffp_flash_seq_test.sv
// Self-checking bench for the flash unlock, erase and write sequencer
`timescale 1ns/100ps
module ffp_flash_seq_test;
   import ffp_pkg::*;
   // Short counts keep the run brief; the window must outlast six key writes
   localparam int unsigned PROG = 20;
   localparam int unsigned UNL  = 40;
   logic        pclk, presetn, psel, penable, pwrite, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic        pready, pslverr, cpu_stall, flash_erase, flash_write;
   logic [6:0]  flash_page;
   logic [4:0]  flash_buf_idx;
   logic [15:0] flash_buf_data;
   int          bad_count, check_count;
   ffp_flash_seq #(.PROG_CYCLES(PROG), .UNLOCK_CYCLES(UNL)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpu_stall(cpu_stall),
      .flash_erase(flash_erase), .flash_write(flash_write),
      .flash_page(flash_page), .flash_buf_idx(flash_buf_idx),
      .flash_buf_data(flash_buf_data));
   always #5 pclk = ~pclk;
   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Request holds until the rising edge that samples pready high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         bad_count++;
         $display("[ERR] pready expected 1 seen %b", pready);
      end
      rdat    = prdata;
      rerr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask : wr
   task automatic rd_chk(input string nm, input logic [11:0] a,
                         input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rdat & m);
   endtask : rd_chk
   task automatic poll(input string nm, input logic [11:0] a, input logic [31:0] m);
      int k;
      k = 0;
      do begin
         apb(1'b0, a, 32'h0);
         k++;
      end while ((rdat & m) !== 32'h0 && k < 40);
      chk(nm, 32'h0, rdat & m);
   endtask : poll
   task automatic unlock(input logic [7:0] flip);
      wr(CTRL_OFS, 8'h68);
      rd_chk("trigger_set", CTRL_OFS, 32'h08, 32'h08);
      for (int i = 0; i < KEY_BYTES; i++)
         wr(KEY_OFS + 12'(4 * i), KEY_PATTERN[8*i +: 8] ^ (i == 2 ? flip : 8'h00));
      poll("trigger_expiry", CTRL_OFS, 32'h08);
   endtask : unlock
   task automatic busy_len(input string nm);
      int k;
      k = 0;
      while (cpu_stall === 1'b1 && k < 1000) begin
         @(negedge pclk);
         k++;
      end
      chk(nm, 32'h1, {31'h0, (k >= PROG) && (k <= PROG + 2)});
   endtask : busy_len
   task automatic buf_chk(input logic [4:0] i, input logic [15:0] e);
      @(posedge pclk);
      flash_buf_idx <= i;
      @(posedge pclk);
      @(negedge pclk);
      chk("buf_word", {16'h0, e}, {16'h0, flash_buf_data});
   endtask : buf_chk
   function automatic logic [31:0] ops();
      return {22'h0, cpu_stall, flash_write, flash_erase, flash_page};
   endfunction : ops
   // Strobes launch at the edge of the go write, so look half a cycle on
   task automatic ops_chk(input string nm, input logic [31:0] e,
                          input logic [31:0] m);
      @(negedge pclk);
      chk(nm, e, ops() & m);
   endtask : ops_chk
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test
   // ==========================================================
   // Scenarios
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, flash_buf_idx} = '0;
      bad_count = 0;
      check_count = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk("ctrl_reset", CTRL_OFS, 32'h0, 32'hFFFF_FFFF);
      wr(CTRL_OFS, 8'h80);
      rd_chk("grant_sw_set", CTRL_OFS, 32'h0, 32'h80);
      apb(1'b0, 12'h030, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, rerr});
      wr(CTRL_OFS, 8'h84);
      ops_chk("go_locked", 32'h0, 32'h380);
      unlock(8'h01);
      rd_chk("grant_bad_key", CTRL_OFS, 32'h0, 32'h80);
      unlock(8'h00);
      rd_chk("grant_good_key", CTRL_OFS, 32'h80, 32'h80);
      wr(ADDRL_OFS, 8'h3C);
      wr(ADDRH_OFS, 8'h05);
      for (int i = 0; i < 6; i++) begin
         wr(WLO_OFS, 8'h10 + 8'(i));
         wr(WHI_OFS, 8'hA0 + 8'(i));
      end
      wr(WLO_OFS, 8'hEE);
      rd_chk("addr_stop", ADDRL_OFS, 32'h3F, 32'hFF);
      buf_chk(5'd28, 16'hA010);
      buf_chk(5'd29, 16'hA111);
      buf_chk(5'd31, 16'hA515);
      wr(CTRL_OFS, 8'hA4);
      ops_chk("go_reserved", 32'h0, 32'h380);
      wr(CTRL_OFS, 8'h84);
      ops_chk("write_run", 32'h329, 32'h3FF);
      busy_len("write_len");
      rd_chk("write_done", CTRL_OFS, 32'h0, 32'h04);
      wr(WIPE_OFS, 8'h01);
      rd_chk("wipe_set", WIPE_OFS, 32'h1, 32'h1);
      poll("wipe_done", WIPE_OFS, 32'h1);
      buf_chk(5'd28, 16'h0000);
      wr(CTRL_OFS, 8'h94);
      ops_chk("erase_run", 32'h2A9, 32'h3FF);
      busy_len("erase_len");
      rd_chk("erase_done", CTRL_OFS, 32'h0, 32'h04);
      wr(CTRL_OFS, 8'h94);
      wr(CTRL_OFS, 8'h10);
      ops_chk("revoke_stop", 32'h0, 32'h380);
      rd_chk("revoke_flag", CTRL_OFS, 32'h0, 32'h80);
      wr(CTRL_OFS, 8'h94);
      ops_chk("go_revoked", 32'h0, 32'h380);
      finish_test();
   end
   // A hang counts as a mismatch
   initial begin
      repeat (5000) @(posedge pclk);
      bad_count++;
      finish_test();
   end
endmodule : ffp_flash_seq_test
